//--- design/ssn_cdc_word.sv
// Purpose: Word crossing between two clocks by toggle request and acknowledge
// Assumes: Source holds nothing; the word is latched while busy
// Notes: One word in flight at a time; dst_valid_o is a one-cycle pulse
`timescale 1ns/1ns
module ssn_cdc_word #(
    parameter int WIDTH = 8
) (
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic src_valid_i,
    input wire logic [WIDTH-1:0] src_data_i,
    output logic src_busy_o,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic dst_valid_o,
    output logic [WIDTH-1:0] dst_data_o
);
    logic req_r;
    logic busy_r;
    logic [WIDTH-1:0] hold_r;
    logic ack_m;
    logic ack_s;
    logic req_m;
    logic req_s;
    logic ack_r;
    logic valid_r;
    logic [WIDTH-1:0] data_r;

    // ==========================================================
    // Source side
    always_ff @(posedge src_clk_i) begin
        ack_m <= ack_r;
        ack_s <= ack_m;
    end

    always_ff @(posedge src_clk_i) begin
        if (src_rst_i) begin
            req_r <= 1'b0;
            busy_r <= 1'b0;
            hold_r <= '0;
        end else if (!busy_r && src_valid_i) begin
            hold_r <= src_data_i;
            req_r <= ~req_r;
            busy_r <= 1'b1;
        end else if (busy_r && (ack_s == req_r)) begin
            busy_r <= 1'b0;
        end
    end

    // ==========================================================
    // Destination side
    always_ff @(posedge dst_clk_i) begin
        req_m <= req_r;
        req_s <= req_m;
    end

    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            ack_r <= 1'b0;
            valid_r <= 1'b0;
            data_r <= '0;
        end else begin
            valid_r <= 1'b0;
            if (req_s != ack_r) begin
                ack_r <= req_s;
                data_r <= hold_r;
                valid_r <= 1'b1;
            end
        end
    end

    assign src_busy_o = busy_r;
    assign dst_valid_o = valid_r;
    assign dst_data_o = data_r;

endmodule // ssn_cdc_word

//--- design/ssn_pkg.sv
// Purpose: Types shared by the status/notify slave
// Assumes: Nothing
// Notes: Constants live in ssn_regs.svh
package ssn_pkg;

    // ==========================================================
    // Link state machine
    typedef enum logic [2:0] {
        SSN_IDLE = 3'b000,
        SSN_RECV = 3'b001,
        SSN_ACK = 3'b010,
        SSN_SEND = 3'b011,
        SSN_MACK = 3'b100
    } ssn_link_state_t;

endpackage

//--- design/ssn_regs.svh
// Purpose: Offsets, field positions and fixed values of the status/notify slave
// Assumes: Included by the slave module and by the test bench
// Notes: Offsets are the command codes that select a status byte
`ifndef SSN_REGS_SVH
`define SSN_REGS_SVH

// ==========================================================
// Command codes (status byte offsets) and the byte returned for other codes
`define SSN_CMD_TIMEOUT_ALERT 8'h04
`define SSN_CMD_BOOT_BATTERY 8'h05
`define SSN_CMD_MESSAGE_ONE 8'h06
`define SSN_CMD_MESSAGE_TWO 8'h07
`define SSN_CMD_WATCHDOG 8'h08
`define SSN_RESERVED_BYTE 8'h00

// ==========================================================
// Field positions
`define SSN_BIT_SECOND_TIMEOUT 3
`define SSN_BIT_ALERT_PIN 7
`define SSN_BIT_BLANK_FLASH 0
`define SSN_BIT_BATTERY_LOW 1
`define SSN_BIT_CPU_FAIL 2

// ==========================================================
// Fixed values
`define SSN_HOST_ADDR 7'h08
`define SSN_BLANK_BYTE 8'hFF
`define SSN_BITS_PER_BYTE 4'h8
`define SSN_NOTIFY_LAST 2'h2

`endif

//--- design/ssn_slave.sv
// Purpose: Management-bus slave returning status bytes and taking host-notify messages
// Assumes: SCL/SDA oversampled on LINK_CLK_I; SDA is open drain, low when SDA_OE_O
// Notes: Status bits are gathered on REF_CLK_I and cross as one word
`timescale 1ns/1ns
`include "ssn_regs.svh"
module ssn_slave
    import ssn_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic LINK_CLK_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic [6:0] SLAVE_ADDR_I,
    input wire logic FIRST_TIMEOUT_I,
    input wire logic SECOND_TIMEOUT_FLAG_I,
    input wire logic GENERAL_INPUT_ELEVEN_I,
    input wire logic INPUT_ELEVEN_INVERT_I,
    input wire logic BOOT_FETCH_VALID_I,
    input wire logic [7:0] BOOT_FETCH_DATA_I,
    input wire logic BATTERY_LOW_N_I,
    input wire logic CPU_POWER_FAIL_FLAG_I,
    input wire logic [7:0] MESSAGE_ONE_I,
    input wire logic [7:0] MESSAGE_TWO_I,
    input wire logic [7:0] WATCHDOG_STATUS_COPY_I,
    input wire logic NOTIFY_CLEAR_I,
    output logic NOTIFY_PENDING_STATUS_O,
    output logic NOTIFY_IRQ_O,
    output logic [6:0] NOTIFY_ADDR_O,
    output logic [7:0] NOTIFY_DATA_LOW_O,
    output logic [7:0] NOTIFY_DATA_HIGH_O
);
    localparam int STAT_W = 47;
    localparam int NOTE_W = 23;

    // ==========================================================
    // Reference domain: pin synchronisers
    logic gpi_m;
    logic gpi_s;
    logic battery_low_n_m;
    logic battery_low_n_s;

    always_ff @(posedge REF_CLK_I) begin
        gpi_m <= GENERAL_INPUT_ELEVEN_I;
        gpi_s <= gpi_m;
        battery_low_n_m <= BATTERY_LOW_N_I;
        battery_low_n_s <= battery_low_n_m;
    end

    // ==========================================================
    // Reference domain: first boot fetch check
    logic fetch_seen_r;
    logic blank_flash_r;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            fetch_seen_r <= 1'b0;
            blank_flash_r <= 1'b0;
        end else if (BOOT_FETCH_VALID_I && !fetch_seen_r) begin
            fetch_seen_r <= 1'b1;
            blank_flash_r <= (BOOT_FETCH_DATA_I == `SSN_BLANK_BYTE);
        end
    end

    // ==========================================================
    // Reference domain: status word assembly
    logic [7:0] timeout_alert_status;
    logic [7:0] boot_battery_power_status;
    logic [STAT_W-1:0] stat_word_r;

    always_comb begin
        timeout_alert_status = 8'h00;
        timeout_alert_status[`SSN_BIT_SECOND_TIMEOUT] =
            FIRST_TIMEOUT_I & SECOND_TIMEOUT_FLAG_I;
        timeout_alert_status[`SSN_BIT_ALERT_PIN] =
            INPUT_ELEVEN_INVERT_I ? gpi_s : ~gpi_s;
        boot_battery_power_status = 8'h00;
        boot_battery_power_status[`SSN_BIT_BLANK_FLASH] = blank_flash_r;
        boot_battery_power_status[`SSN_BIT_BATTERY_LOW] = ~battery_low_n_s;
        boot_battery_power_status[`SSN_BIT_CPU_FAIL] = CPU_POWER_FAIL_FLAG_I;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            stat_word_r <= '0;
        end else begin
            stat_word_r <= {SLAVE_ADDR_I, WATCHDOG_STATUS_COPY_I, MESSAGE_TWO_I,
                            MESSAGE_ONE_I, boot_battery_power_status,
                            timeout_alert_status};
        end
    end

    // ==========================================================
    // Link domain: reset and pin synchronisers
    logic lrst_m;
    logic link_rst;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic pend_m;
    logic pend_s;

    always_ff @(posedge LINK_CLK_I) begin
        lrst_m <= RST_I;
        link_rst <= lrst_m;
        scl_m <= SCL_I;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= SDA_I;
        sda_s <= sda_m;
        sda_d <= sda_s;
        pend_m <= NOTIFY_PENDING_STATUS_O;
        pend_s <= pend_m;
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // Crossings
    logic stat_valid;
    logic [STAT_W-1:0] stat_link;
    logic [STAT_W-1:0] stat_snap_r;
    logic nf_busy;
    logic nf_done_r;
    logic [6:0] nf_addr_r;
    logic [7:0] nf_low_r;
    logic [7:0] nf_high_r;
    logic nf_valid;
    logic [NOTE_W-1:0] nf_word;

    ssn_cdc_word #(.WIDTH(STAT_W)) u_stat_cdc (
        .src_clk_i(REF_CLK_I),
        .src_rst_i(RST_I),
        .src_valid_i(1'b1),
        .src_data_i(stat_word_r),
        .src_busy_o(),
        .dst_clk_i(LINK_CLK_I),
        .dst_rst_i(link_rst),
        .dst_valid_o(stat_valid),
        .dst_data_o(stat_link)
    );

    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            stat_snap_r <= '0;
        end else if (stat_valid) begin
            stat_snap_r <= stat_link;
        end
    end

    ssn_cdc_word #(.WIDTH(NOTE_W)) u_note_cdc (
        .src_clk_i(LINK_CLK_I),
        .src_rst_i(link_rst),
        .src_valid_i(nf_done_r),
        .src_data_i({nf_addr_r, nf_high_r, nf_low_r}),
        .src_busy_o(nf_busy),
        .dst_clk_i(REF_CLK_I),
        .dst_rst_i(RST_I),
        .dst_valid_o(nf_valid),
        .dst_data_o(nf_word)
    );

    // ==========================================================
    // Link domain: byte decisions
    ssn_link_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic addr_phase_r;
    logic is_notify_r;
    logic [1:0] byte_idx_r;
    logic have_cmd_r;
    logic send_next_r;
    logic [7:0] cmd_r;
    logic [7:0] tx_r;
    logic sda_oe_r;
    logic slave_hit;
    logic host_hit;
    logic byte_ack;
    logic [7:0] tx_byte;

    assign slave_hit = (shift_r[7:1] == stat_snap_r[46:40]);
    assign host_hit = (shift_r[7:1] == `SSN_HOST_ADDR) && !shift_r[0]
                      && !slave_hit && !pend_s && !nf_busy;

    always_comb begin
        if (addr_phase_r) begin
            byte_ack = slave_hit | host_hit;
        end else if (is_notify_r) begin
            byte_ack = (byte_idx_r <= `SSN_NOTIFY_LAST);
        end else begin
            byte_ack = (byte_idx_r == 2'h0);
        end
    end

    always_comb begin
        case (cmd_r)
            `SSN_CMD_TIMEOUT_ALERT: tx_byte = stat_snap_r[7:0];
            `SSN_CMD_BOOT_BATTERY: tx_byte = stat_snap_r[15:8];
            `SSN_CMD_MESSAGE_ONE: tx_byte = stat_snap_r[23:16];
            `SSN_CMD_MESSAGE_TWO: tx_byte = stat_snap_r[31:24];
            `SSN_CMD_WATCHDOG: tx_byte = stat_snap_r[39:32];
            default: tx_byte = `SSN_RESERVED_BYTE;
        endcase
    end

    // ==========================================================
    // Link domain: bit-level state machine
    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            state_r <= SSN_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            addr_phase_r <= 1'b0;
            is_notify_r <= 1'b0;
            byte_idx_r <= 2'h0;
            have_cmd_r <= 1'b0;
            send_next_r <= 1'b0;
            cmd_r <= 8'h00;
            tx_r <= 8'h00;
            sda_oe_r <= 1'b0;
            nf_addr_r <= 7'h00;
            nf_low_r <= 8'h00;
            nf_high_r <= 8'h00;
            nf_done_r <= 1'b0;
        end else begin
            nf_done_r <= 1'b0;
            if (start_det) begin
                state_r <= SSN_RECV;
                bit_cnt_r <= 4'h0;
                addr_phase_r <= 1'b1;
                sda_oe_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= SSN_IDLE;
                have_cmd_r <= 1'b0;
                sda_oe_r <= 1'b0;
            end else begin
                case (state_r)
                    SSN_RECV: begin
                        if (scl_rise && (bit_cnt_r != `SSN_BITS_PER_BYTE)) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && (bit_cnt_r == `SSN_BITS_PER_BYTE)) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe_r <= byte_ack;
                            state_r <= byte_ack ? SSN_ACK : SSN_IDLE;
                            addr_phase_r <= 1'b0;
                            if (addr_phase_r) begin
                                is_notify_r <= host_hit;
                                byte_idx_r <= 2'h0;
                                send_next_r <= slave_hit && have_cmd_r;
                                tx_r <= tx_byte;
                            end else begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                                if (!is_notify_r) begin
                                    cmd_r <= shift_r;
                                    have_cmd_r <= 1'b1;
                                end else begin
                                    case (byte_idx_r)
                                        2'h0: nf_addr_r <= shift_r[7:1];
                                        2'h1: nf_low_r <= shift_r;
                                        2'h2: begin
                                            nf_high_r <= shift_r;
                                            nf_done_r <= 1'b1;
                                        end
                                        default: begin
                                        end
                                    endcase
                                end
                            end
                        end
                    end
                    SSN_ACK: begin
                        if (scl_fall) begin
                            if (send_next_r) begin
                                sda_oe_r <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= 4'h1;
                                state_r <= SSN_SEND;
                            end else begin
                                sda_oe_r <= 1'b0;
                                state_r <= SSN_RECV;
                            end
                        end
                    end
                    SSN_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == `SSN_BITS_PER_BYTE) begin
                                sda_oe_r <= 1'b0;
                                state_r <= SSN_MACK;
                            end else begin
                                sda_oe_r <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    SSN_MACK: begin
                        if (scl_rise) begin
                            state_r <= SSN_IDLE;
                        end
                    end
                    default: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Reference domain: notify registers and pending status
    logic pending_r;
    logic irq_r;
    logic [6:0] note_addr_r;
    logic [7:0] note_low_r;
    logic [7:0] note_high_r;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pending_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= nf_valid;
            if (nf_valid) begin
                pending_r <= 1'b1;
            end else if (NOTIFY_CLEAR_I) begin
                pending_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            note_addr_r <= 7'h00;
            note_low_r <= 8'h00;
            note_high_r <= 8'h00;
        end else if (nf_valid && !pending_r) begin
            note_addr_r <= nf_word[22:16];
            note_high_r <= nf_word[15:8];
            note_low_r <= nf_word[7:0];
        end
    end

    // ==========================================================
    // Outputs
    logic sda_level_r;

    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            sda_level_r <= 1'b0;
        end else begin
            sda_level_r <= 1'b0;
        end
    end

    assign SDA_O = sda_level_r;
    assign SDA_OE_O = sda_oe_r;
    assign NOTIFY_PENDING_STATUS_O = pending_r;
    assign NOTIFY_IRQ_O = irq_r;
    assign NOTIFY_ADDR_O = note_addr_r;
    assign NOTIFY_DATA_LOW_O = note_low_r;
    assign NOTIFY_DATA_HIGH_O = note_high_r;

endmodule // ssn_slave

//--- sim/ssn_master_model.sv
// Purpose: Bus master model bit-banging the two-wire bus
// Assumes: SDA pulled up in the bench; SCL stands high between frames
// Notes: Each quarter bit lasts Q link clock cycles
`timescale 1ns/1ns
module ssn_master_model
    import ssn_pkg::*;
#(
    parameter int Q = 12
) (
    input wire logic link_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    // Start or repeated start: SDA falls while SCL high
    task automatic start();
        sda_low_o <= 1'b0;
        tk(Q);
        scl_o <= 1'b1;
        tk(Q);
        sda_low_o <= 1'b1;
        tk(Q);
        scl_o <= 1'b0;
        tk(Q);
    endtask

    task automatic stop();
        sda_low_o <= 1'b1;
        tk(Q);
        scl_o <= 1'b1;
        tk(Q);
        sda_low_o <= 1'b0;
        tk(4 * Q);
    endtask

    // Data moves only while SCL low, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low_o <= !b;
        tk(Q);
        scl_o <= 1'b1;
        tk(Q);
        r = sda_i;
        tk(Q);
        scl_o <= 1'b0;
        tk(Q);
    endtask

    // Byte MSB first, then released ninth bit
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, n);
        ack = !n;
    endtask
endmodule // ssn_master_model

//--- sim/ssn_slave_checker.sv
// Purpose: Port assertions for the status/notify slave
// Assumes: Both domains are reset by RST_I
// Notes: Pins checked on LINK_CLK_I, notify results on REF_CLK_I
`timescale 1ns/1ns
module ssn_slave_checker
    import ssn_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic LINK_CLK_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic NOTIFY_CLEAR_I,
    input wire logic NOTIFY_PENDING_STATUS_O,
    input wire logic NOTIFY_IRQ_O,
    input wire logic [6:0] NOTIFY_ADDR_O,
    input wire logic [7:0] NOTIFY_DATA_LOW_O,
    input wire logic [7:0] NOTIFY_DATA_HIGH_O
);
    // ==========================================================
    // Bus pins
    open_drain_a: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        SDA_OE_O |-> SDA_O == 1'b0) else $error("SDA driven high");
    sda_steady_a: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        $changed(SDA_OE_O) |-> !SCL_I) else $error("SDA moved while SCL high");

    // ==========================================================
    // Notify results
    irq_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_IRQ_O |=> !NOTIFY_IRQ_O) else $error("interrupt longer than a cycle");
    irq_sets_pend_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_IRQ_O |-> ##[0:1] NOTIFY_PENDING_STATUS_O) else $error("no pending after irq");
    pend_has_irq_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(NOTIFY_PENDING_STATUS_O) |-> $past(NOTIFY_IRQ_O) or ##[0:1] NOTIFY_IRQ_O)
        else $error("pending rose without irq");
    pend_holds_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_PENDING_STATUS_O && !NOTIFY_CLEAR_I |=> NOTIFY_PENDING_STATUS_O)
        else $error("pending dropped without clear");
    clear_drops_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_CLEAR_I && !NOTIFY_IRQ_O |=> !NOTIFY_PENDING_STATUS_O || NOTIFY_IRQ_O)
        else $error("clear ignored");
    notify_frozen_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_PENDING_STATUS_O && $past(NOTIFY_PENDING_STATUS_O)
        && $past(NOTIFY_PENDING_STATUS_O, 2) |-> $stable(NOTIFY_ADDR_O)
        && $stable(NOTIFY_DATA_LOW_O) && $stable(NOTIFY_DATA_HIGH_O))
        else $error("notify data changed while pending");
    irq_when_free_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        NOTIFY_IRQ_O |-> !$past(NOTIFY_PENDING_STATUS_O, 2)) else $error("irq while pending");
    addr_change_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        !$stable(NOTIFY_ADDR_O) |-> ##[0:1] NOTIFY_PENDING_STATUS_O)
        else $error("address changed without notify");
endmodule // ssn_slave_checker

bind ssn_slave ssn_slave_checker u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .LINK_CLK_I(LINK_CLK_I), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .NOTIFY_CLEAR_I(NOTIFY_CLEAR_I),
    .NOTIFY_PENDING_STATUS_O(NOTIFY_PENDING_STATUS_O), .NOTIFY_IRQ_O(NOTIFY_IRQ_O),
    .NOTIFY_ADDR_O(NOTIFY_ADDR_O), .NOTIFY_DATA_LOW_O(NOTIFY_DATA_LOW_O),
    .NOTIFY_DATA_HIGH_O(NOTIFY_DATA_HIGH_O)
);

//--- sim/ssn_slave_test.sv
// Purpose: Self-checking bench for the status/notify slave
// Assumes: Master model drives the bus; SDA has a pull-up
// Notes: Status inputs change only between transfers
`timescale 1ns/1ns
`include "ssn_regs.svh"
module ssn_slave_test
    import ssn_pkg::*;
;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] slv = 7'h3A;
    logic ft, st, gpi, inv, bfv, bat_n, cpu, clr, blank;
    logic [7:0] bfd, m1, m2, wd, n_lo, n_hi;
    logic [6:0] n_addr;
    logic sda_o, sda_oe, m_scl, m_low, pend, irq;
    logic [7:0] rsv [4] = '{8'h00, 8'h03, 8'h09, 8'hFF};
    int n_mismatch = 0;
    int num_checks = 0;
    int n_irq = 0;
    wire sda = !m_low && (sda_oe ? sda_o : 1'b1);

    always #20 clk = !clk;
    always #3 lclk = !lclk;

    ssn_slave DUT (
        .REF_CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .SCL_I(m_scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SLAVE_ADDR_I(slv), .FIRST_TIMEOUT_I(ft),
        .SECOND_TIMEOUT_FLAG_I(st), .GENERAL_INPUT_ELEVEN_I(gpi), .INPUT_ELEVEN_INVERT_I(inv),
        .BOOT_FETCH_VALID_I(bfv), .BOOT_FETCH_DATA_I(bfd), .BATTERY_LOW_N_I(bat_n),
        .CPU_POWER_FAIL_FLAG_I(cpu), .MESSAGE_ONE_I(m1), .MESSAGE_TWO_I(m2),
        .WATCHDOG_STATUS_COPY_I(wd), .NOTIFY_CLEAR_I(clr), .NOTIFY_PENDING_STATUS_O(pend),
        .NOTIFY_IRQ_O(irq), .NOTIFY_ADDR_O(n_addr), .NOTIFY_DATA_LOW_O(n_lo),
        .NOTIFY_DATA_HIGH_O(n_hi)
    );
    ssn_master_model u_mst (.link_clk_i(lclk), .sda_i(sda), .scl_o(m_scl), .sda_low_o(m_low));

    always @(posedge clk) begin
        if (irq === 1'b1) begin
            n_irq <= n_irq + 1;
        end
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus operations
    task automatic do_reset(input logic [7:0] first);
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bfv <= 1'b1;
        bfd <= first;
        @(posedge clk);
        bfd <= ~first;
        @(posedge clk);
        bfv <= 1'b0;
        blank = (first == `SSN_BLANK_BYTE);
        repeat (60) @(posedge clk);
        check({1'b0, n_addr}, 8'h00, "address after reset");
        check({7'h00, pend}, 8'h00, "pending after reset");
    endtask

    task automatic rd(input logic [7:0] cmd, input logic rw1, input logic rw2,
            input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        u_mst.start();
        u_mst.xfer({slv, rw1}, d, a);
        check({7'h00, a}, 8'h01, "first address ack");
        u_mst.xfer(cmd, d, a);
        check({7'h00, a}, 8'h01, "command ack");
        u_mst.start();
        u_mst.xfer({slv, rw2}, d, a);
        check({7'h00, a}, 8'h01, "second address ack");
        u_mst.xfer(8'hFF, d, a);
        u_mst.stop();
        check(d, exp, "status byte");
    endtask

    task automatic probe(input logic [7:0] b, input logic ok);
        logic a;
        logic [7:0] d;
        u_mst.start();
        u_mst.xfer(b, d, a);
        u_mst.stop();
        check({7'h00, a}, {7'h00, ok}, "address ack");
    endtask

    // Inputs packed as ft, st, pin, invert, battery_n, cpu, rw1, rw2
    task automatic stat(input logic [7:0] v);
        logic [7:0] e4, e5;
        @(posedge clk);
        {ft, st, gpi, inv, bat_n, cpu} <= v[7:2];
        repeat (30) @(posedge clk);
        e4 = `SSN_RESERVED_BYTE;
        e5 = `SSN_RESERVED_BYTE;
        e4[`SSN_BIT_SECOND_TIMEOUT] = v[7] & v[6];
        e4[`SSN_BIT_ALERT_PIN] = v[4] ? v[5] : !v[5];
        e5[`SSN_BIT_BLANK_FLASH] = blank;
        e5[`SSN_BIT_BATTERY_LOW] = !v[3];
        e5[`SSN_BIT_CPU_FAIL] = v[2];
        rd(`SSN_CMD_TIMEOUT_ALERT, v[1], v[0], e4);
        rd(`SSN_CMD_BOOT_BATTERY, v[1], v[0], e5);
    endtask

    task automatic notify(input logic [6:0] dev, input logic [7:0] lo, input logic [7:0] hi,
            input logic ok);
        logic a;
        logic [7:0] d;
        u_mst.start();
        u_mst.xfer({`SSN_HOST_ADDR, 1'b0}, d, a);
        check({7'h00, a}, {7'h00, ok}, "host address ack");
        if (a === 1'b1) begin
            u_mst.xfer({dev, 1'b0}, d, a);
            check({7'h00, a}, 8'h01, "sender ack");
            u_mst.xfer(lo, d, a);
            check({7'h00, a}, 8'h01, "low byte ack");
            u_mst.xfer(hi, d, a);
            check({7'h00, a}, 8'h01, "high byte ack");
        end
        u_mst.stop();
    endtask

    task automatic wait_pend();
        int i;
        for (i = 0; i < 200 && pend !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 200) begin
            $display("BAD t=%0t pending never rose", $time);
            n_mismatch++;
            close_out();
        end
    endtask

    task automatic chk_note(input logic [6:0] dev, input logic [7:0] lo, input logic [7:0] hi);
        check({1'b0, n_addr}, {1'b0, dev}, "notify address");
        check(n_lo, lo, "notify low");
        check(n_hi, hi, "notify high");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {ft, st, gpi, inv, bfv, cpu, clr} = 7'h00;
        bat_n = 1'b1;
        bfd = 8'h00;
        m1 = 8'hA5;
        m2 = 8'h3C;
        wd = 8'h5A;
        do_reset(8'hFF);
        stat(8'hE5);
        stat(8'hBB);
        stat(8'h48);
        stat(8'hD2);
        $display("status test done");
        rd(`SSN_CMD_MESSAGE_ONE, 1'b0, 1'b1, m1);
        rd(`SSN_CMD_MESSAGE_TWO, 1'b0, 1'b1, m2);
        rd(`SSN_CMD_WATCHDOG, 1'b0, 1'b1, wd);
        foreach (rsv[i]) begin
            rd(rsv[i], 1'b0, 1'b1, `SSN_RESERVED_BYTE);
        end
        probe({slv ^ 7'h01, 1'b0}, 1'b0);
        $display("register test done");
        notify(7'h2C, 8'h11, 8'h22, 1'b1);
        wait_pend();
        chk_note(7'h2C, 8'h11, 8'h22);
        check(n_irq[7:0], 8'h01, "interrupt count");
        notify(7'h15, 8'h33, 8'h44, 1'b0);
        repeat (40) @(posedge clk);
        check({7'h00, pend}, 8'h01, "pending held");
        chk_note(7'h2C, 8'h11, 8'h22);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (4) @(posedge clk);
        check({7'h00, pend}, 8'h00, "pending cleared");
        probe({`SSN_HOST_ADDR, 1'b1}, 1'b0);
        notify(7'h15, 8'h33, 8'h44, 1'b1);
        wait_pend();
        chk_note(7'h15, 8'h33, 8'h44);
        check(n_irq[7:0], 8'h02, "interrupt count");
        $display("notify test done");
        do_reset(8'h00);
        stat(8'hE5);
        $display("second reset test done");
        close_out();
    end

    initial begin
        repeat (100000) @(posedge clk);
        $display("BAD t=%0t run too long", $time);
        n_mismatch++;
        close_out();
    end
endmodule // ssn_slave_test
